// >>> rtl/tws_map.vh
/*
 * Constants for the two-wire serial memory slave.
 * Assumes it is included by bare name from every design file.
 */
`ifndef TWS_MAP_VH
`define TWS_MAP_VH

// Array geometry
`define TWS_ADDR_W     11
`define TWS_DATA_W     8
`define TWS_MEM_DEPTH  2048
`define TWS_PAGE_W     3

// Bits in one byte, and the protected-half select bit of the address
`define TWS_BYTE_BITS  4'h8
`define TWS_LAST_BIT   4'h7
`define TWS_PROT_BIT   10

// Write queue: address plus data per entry, four entries
`define TWS_FIFO_W     19
`define TWS_FIFO_D     4
`define TWS_FIFO_AW    2

// Device-type code; the value is arbitrary
`define TWS_DEV_TYPE   4'h5

`endif

// >>> rtl/tws_fifo.v
/*
 * Holds no logic: the write queue module sits beside the slave in tws_slave.v.
 * Assumes that file is read in every build of the slave.
 */

// >>> rtl/tws_slave.v
/*
 * Two-wire bus slave in front of a 2048 x 8 memory array, and the
 * four-entry write queue module that feeds the array.
 * Assumes SCL, SDA and the write-protect pin are asynchronous
 * to clk and are sampled well above the bus bit rate; the open-drain
 * wire level is resolved outside from sda_oe.
 */
//
// Behaviour
// - Falling SDA with SCL high is start
// - Start aborts everything, awaits slave address
// - Rising SDA with SCL high stops, aborts
// - SDA stable while SCL high; sampled then
// - Transmitter releases SDA; receiver acks ninth clock
// - Missing acknowledge ends operation, readdressable
// - Keep sending read bytes while master acks
// - Respond only to matching device-type nibble
// - Bits 3-1 pick page, bit 0 direction
// - Write word address forms 11-bit latch
// - Reads latch page, reuse low address
// - Address advances before each acknowledge slot
// - Address wraps from top to zero
// - Byte count per operation is unlimited
// - Read eight bits, then sample acknowledge
// - Write receives eight bits, then acknowledges
// - Every byte travels most significant first
// - Commit after eighth bit, before acknowledge
// - No busy period after writes
// - Protect pin guards upper half, no ack
// - Protected write leaves address counter unchanged
// - Sample on SCL rise, change after fall
// - Word address stays after repeated start
//
`include "tws_map.vh"

module tws_slave (
    // Clock and reset
    input  wire        clk,
    input  wire        sys_rst,
    // Two-wire bus pins
    input  wire        scl_in,
    input  wire        sda_in,
    output wire        sda_out,
    output reg         sda_oe,
    // Write-protect pin
    input  wire        wp_in,
    // Array write pause, back-pressures the write queue
    input  wire        hold_writes
);
    // Transfer states
    localparam [2:0] ST_IDLE = 3'h0;   // Ignoring bus until start
    localparam [2:0] ST_DEV  = 3'h1;   // Receiving slave address
    localparam [2:0] ST_WORD = 3'h2;   // Receiving word address
    localparam [2:0] ST_WDAT = 3'h3;   // Receiving write data
    localparam [2:0] ST_RDAT = 3'h4;   // Sending read data

    // Pin synchronisers
    reg        scl_m;                  // SCL first stage
    reg        scl_s;                  // SCL second stage
    reg        sda_m;                  // SDA first stage
    reg        sda_s;                  // SDA second stage
    reg        wp_m;                   // Protect first stage
    reg        wp_s;                   // Protect second stage
    reg        scl_p;                  // SCL one cycle back
    reg        sda_p;                  // SDA one cycle back

    // Protocol state
    reg  [2:0] state;                  // Transfer state
    reg  [3:0] bit_cnt;                // Bits done in this byte
    reg        ack_ph;                 // Inside acknowledge slot
    reg        ack_ok;                 // Device will acknowledge
    reg        rd_dir;                 // Latched direction bit
    reg  [7:0] rx_sh;                  // Receive shift register
    reg  [7:0] tx_sh;                  // Transmit shift register
    reg  [`TWS_ADDR_W-1:0] addr;       // Page and word address latch

    // Write path
    reg        commit;                 // One-cycle byte commit pulse
    reg        wr_req;                 // Entry waiting for the queue
    reg  [`TWS_FIFO_W-1:0] wr_word;    // Address and data to queue
    wire       q_in_ready;             // Queue can take an entry
    wire       q_out_valid;            // Queue holds an entry
    wire [`TWS_FIFO_W-1:0] q_out_data; // Oldest queued entry

    // Memory array and read port
    reg  [7:0] mem [0:`TWS_MEM_DEPTH-1];
    reg  [7:0] rd_q;                   // Byte at the current address

    // Edge detectors sit behind the synchronisers; their reset value is
    // the idle bus level, so no false edge follows reset.
    // Bus events
    wire scl_rise = scl_s & ~scl_p;
    wire scl_fall = ~scl_s & scl_p;
    // SDA falls with SCL high
    wire start_ev = scl_s & scl_p & sda_p & ~sda_s;
    // SDA rises with SCL high
    wire stop_ev  = scl_s & scl_p & ~sda_p & sda_s;

    // Byte as it stands after the bit now arriving
    wire [7:0] next_byte = {rx_sh[6:0], sda_s};

    // Write target falls in the guarded upper half
    wire prot_hit = wp_s & addr[`TWS_PROT_BIT];

    // SDA moves only one clock after a seen SCL fall, three after the pin falls, inside the low
    // phase, so the device never forms a start or stop by itself.
    // Open drain: only ever pulls low
    assign sda_out = 1'b0;

    // Two-flop synchronisers for SCL, SDA and the protect pin; hold_writes is used unsynchronised
    always @(posedge clk) begin
        if (sys_rst) begin
            scl_m <= 1'b1;
            scl_s <= 1'b1;
            sda_m <= 1'b1;
            sda_s <= 1'b1;
            wp_m  <= 1'b0;
            wp_s  <= 1'b0;
            scl_p <= 1'b1;
            sda_p <= 1'b1;
        end else begin
            scl_m <= scl_in;
            scl_s <= scl_m;
            sda_m <= sda_in;
            sda_s <= sda_m;
            wp_m  <= wp_in;
            wp_s  <= wp_m;
            scl_p <= scl_s;
            sda_p <= sda_s;
        end
    end

    // Start and stop are tested first, so they win over any bit event
    // that arrives in the same cycle.
    // Main protocol engine
    always @(posedge clk) begin
        if (sys_rst) begin
            state   <= ST_IDLE;
            bit_cnt <= 4'h0;
            ack_ph  <= 1'b0;
            ack_ok  <= 1'b0;
            rd_dir  <= 1'b0;
            rx_sh   <= 8'h00;
            tx_sh   <= 8'h00;
            addr    <= {`TWS_ADDR_W{1'b0}};
            sda_oe  <= 1'b0;
            commit  <= 1'b0;
            wr_word <= {`TWS_FIFO_W{1'b0}};
        end else begin
            commit <= 1'b0;
            if (start_ev) begin
                // Abort and wait for a slave address
                state   <= ST_DEV;
                bit_cnt <= 4'h0;
                ack_ph  <= 1'b0;
                sda_oe  <= 1'b0;
            end else if (stop_ev) begin
                // Abort and go quiet
                state   <= ST_IDLE;
                bit_cnt <= 4'h0;
                ack_ph  <= 1'b0;
                sda_oe  <= 1'b0;
            end else begin
                case (state)
                    ST_IDLE: begin
                        // Bus ignored, line released
                        sda_oe <= 1'b0;
                    end
                    ST_RDAT: begin
                        if (scl_rise && !ack_ph) begin
                            // Master took a bit
                            bit_cnt <= bit_cnt + 4'h1;
                            if (bit_cnt == `TWS_LAST_BIT) begin
                                // Advance, wrapping at the top
                                addr <= addr + 1'b1;
                            end
                        end else if (scl_fall && !ack_ph) begin
                            if (bit_cnt == `TWS_BYTE_BITS) begin
                                // Release for the master's ack
                                sda_oe <= 1'b0;
                                ack_ph <= 1'b1;
                            end else begin
                                // Next bit, changed after the fall
                                sda_oe <= ~tx_sh[6];
                                tx_sh  <= {tx_sh[6:0], 1'b0};
                            end
                        end else if (scl_rise && ack_ph) begin
                            if (sda_s) begin
                                // No ack: read concluded
                                state <= ST_IDLE;
                            end
                        end else if (scl_fall && ack_ph) begin
                            // Ack seen: send the next byte
                            ack_ph  <= 1'b0;
                            bit_cnt <= 4'h0;
                            tx_sh   <= rd_q;
                            sda_oe  <= ~rd_q[7];
                        end
                    end
                    default: begin
                        if (scl_rise && !ack_ph &&
                            bit_cnt != `TWS_BYTE_BITS) begin
                            // Sample while SCL is high
                            rx_sh   <= next_byte;
                            bit_cnt <= bit_cnt + 4'h1;
                            if (bit_cnt == `TWS_LAST_BIT) begin
                                case (state)
                                    ST_DEV: begin
                                        // Match type, latch page
                                        ack_ok <= (next_byte[7:4] ==
                                                   `TWS_DEV_TYPE);
                                        if (next_byte[7:4] ==
                                            `TWS_DEV_TYPE) begin
                                            addr[10:8] <=
                                                next_byte[3:1];
                                            rd_dir <= next_byte[0];
                                        end
                                    end
                                    ST_WORD: begin
                                        // Low address into latch
                                        addr[7:0] <= next_byte;
                                        ack_ok    <= 1'b1;
                                    end
                                    default: begin
                                        if (prot_hit) begin
                                            // Refuse, keep address
                                            ack_ok <= 1'b0;
                                        end else begin
                                            // Commit before ack slot
                                            commit  <= 1'b1;
                                            wr_word <= {addr, next_byte};
                                            addr    <= addr + 1'b1;
                                            ack_ok  <= 1'b1;
                                        end
                                    end
                                endcase
                            end
                        end else if (scl_fall && !ack_ph &&
                                     bit_cnt == `TWS_BYTE_BITS) begin
                            // Drive ack low only for accepted bytes
                            ack_ph <= 1'b1;
                            sda_oe <= ack_ok;
                        end else if (scl_fall && ack_ph) begin
                            // End of ninth clock
                            ack_ph  <= 1'b0;
                            bit_cnt <= 4'h0;
                            sda_oe  <= 1'b0;
                            if (!ack_ok) begin
                                // No ack: back to waiting
                                state <= ST_IDLE;
                            end else begin
                                case (state)
                                    ST_DEV: begin
                                        if (rd_dir) begin
                                            // Current address read
                                            state  <= ST_RDAT;
                                            tx_sh  <= rd_q;
                                            sda_oe <= ~rd_q[7];
                                        end else begin
                                            state <= ST_WORD;
                                        end
                                    end
                                    ST_WORD: begin
                                        state <= ST_WDAT;
                                    end
                                    default: begin
                                        // Keep accepting bytes
                                        state <= ST_WDAT;
                                    end
                                endcase
                            end
                        end
                    end
                endcase
            end
        end
    end

    // A commit that meets a full queue with an entry still pending would
    // replace that entry; hold_writes must stay short.
    // Hold a committed byte until the queue accepts it
    always @(posedge clk) begin
        if (sys_rst) begin
            wr_req <= 1'b0;
        end else if (commit) begin
            wr_req <= 1'b1;
        end else if (q_in_ready) begin
            wr_req <= 1'b0;
        end
    end

    // Write queue between the bus and the array
    tws_fifo #(
        .W  (`TWS_FIFO_W),
        .D  (`TWS_FIFO_D),
        .AW (`TWS_FIFO_AW)
    ) u_wq (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .in_valid  (wr_req),
        .in_ready  (q_in_ready),
        .in_data   (wr_word),
        .out_valid (q_out_valid),
        .out_ready (~hold_writes),
        .out_data  (q_out_data)
    );

    // Array write from the queue; no busy time seen on the bus
    always @(posedge clk) begin
        if (q_out_valid && !hold_writes) begin
            mem[q_out_data[18:8]] <= q_out_data[7:0];
        end
    end

    // Reads see the array only: a byte still parked in the queue is not
    // visible to a read of the same address.
    // Array read at the latched address, refreshed every cycle
    always @(posedge clk) begin
        if (sys_rst) begin
            rd_q <= 8'h00;
        end else begin
            rd_q <= mem[addr];
        end
    end
endmodule // tws_slave

// Write queue: entries wait here while array writes are paused.
// Full and empty come from one extra wrap bit on each pointer, so all
// entries are usable without a separate fill counter.
module tws_fifo #(
    parameter W  = 19,             // Entry width
    parameter D  = 4,              // Entry count
    parameter AW = 2               // Pointer width, log2 of D
) (
    // Clock and reset
    input  wire          clk,
    input  wire          sys_rst,
    // Filling side
    input  wire          in_valid,
    output wire          in_ready,
    input  wire [W-1:0]  in_data,
    // Draining side
    output wire          out_valid,
    input  wire          out_ready,
    output wire [W-1:0]  out_data
);
    reg  [W-1:0]  store [0:D-1];   // Entry storage
    reg  [AW:0]   wr_ptr;          // Write pointer with wrap bit
    reg  [AW:0]   rd_ptr;          // Read pointer with wrap bit

    // Full when pointers differ only in the wrap bit
    assign in_ready  = ~((wr_ptr[AW] != rd_ptr[AW]) &&
                         (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]));
    // Empty when pointers are equal
    assign out_valid = (wr_ptr != rd_ptr);
    assign out_data  = store[rd_ptr[AW-1:0]];

    // Pointer and storage update
    always @(posedge clk) begin
        if (sys_rst) begin
            wr_ptr <= {(AW+1){1'b0}};
            rd_ptr <= {(AW+1){1'b0}};
        end else begin
            if (in_valid && in_ready) begin
                store[wr_ptr[AW-1:0]] <= in_data;
                wr_ptr                <= wr_ptr + 1'b1;
            end
            if (out_valid && out_ready) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
        end
    end
endmodule // tws_fifo

// >>> testbench/tws_slave_monitor.sv
/* Assertion checker for the two-wire memory slave pins.
   Assumes it is bound to the slave and sees only its ports. */
`include "tws_map.vh"
module tws_slave_monitor (
    // Clock and reset
    input wire clk,
    input wire sys_rst,
    // Bus pins
    input wire scl_in,
    input wire sda_in,
    input wire sda_out,
    input wire sda_oe,
    // Side pins
    input wire wp_in,
    input wire hold_writes
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking mon_cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    logic       scl_q;  // SCL one clock back
    logic       sda_q;  // SDA one clock back
    logic [7:0] sh;     // Bits taken at SCL rises
    logic [3:0] bits;   // Rises since the last start
    logic       miss;   // Type nibble did not match
    logic [5:0] st_cnt; // Countdown after a start
    logic [3:0] sp_cnt; // Clocks since a stop
    wire st_ev = scl_in & scl_q & sda_q & ~sda_in; // Start on the pins
    wire sp_ev = scl_in & scl_q & ~sda_q & sda_in; // Stop on the pins
    wire rise  = scl_in & ~scl_q;                  // SCL rising
    wire hit   = rise && bits == 4'h7 && sh[6:3] == `TWS_DEV_TYPE;
    // Pin history, address capture and idle counters
    always @(posedge clk) begin
        scl_q <= scl_in;
        sda_q <= sda_in;
        if (sys_rst || st_ev) begin
            bits <= 4'h0;
            miss <= 1'b0;
        end else if (rise && bits != 4'hF) begin
            bits <= bits + 4'h1;
            sh   <= {sh[6:0], sda_in};
            miss <= miss | (bits == 4'h7 && sh[6:3] != `TWS_DEV_TYPE);
        end
        if (sys_rst || st_ev)
            st_cnt <= sys_rst ? 6'h00 : 6'h3F;
        else if (st_cnt != 6'h00)
            st_cnt <= st_cnt - 6'h01;
        if (sys_rst || st_ev)
            sp_cnt <= 4'h0;
        else if (sp_ev)
            sp_cnt <= 4'h1;
        else if (sp_cnt != 4'h0 && sp_cnt != 4'hF)
            sp_cnt <= sp_cnt + 4'h1;
    end
    a_open_drain: assert property (sda_out == 1'b0)
        else $error("SDA output value not low");
    a_reset_idle: assert property ($fell(sys_rst) |-> !sda_oe)
        else $error("SDA driven at reset release");
    a_rise_scl_low: assert property ($rose(sda_oe) |->
        !$past(scl_in) && !$past(scl_in, 3)) else $error("SDA pulled outside SCL low");
    a_oe_hold: assert property ($rose(sda_oe) |-> sda_oe [*6])
        else $error("SDA pull dropped too soon");
    a_start_quiet: assert property (st_cnt != 6'h00 && st_cnt < 6'h39 |-> !sda_oe)
        else $error("SDA driven during slave address");
    a_stop_idle: assert property (sp_cnt > 4'h4 |-> !sda_oe)
        else $error("SDA driven after stop");
    a_type_miss: assert property (miss |-> !sda_oe)
        else $error("SDA driven for foreign address");
    a_addr_ack: assert property (hit |-> ##[4:14] sda_oe)
        else $error("Address not acknowledged");
    cover property (hit);
    cover property (miss);
    cover property (sp_ev);
endmodule // tws_slave_monitor

// >>> testbench/tws_master_model.sv
/* Two-wire bus master model: drives SCL and pulls SDA low.
   Assumes the bench resolves SDA from both pull enables. */
module tws_master_model (
    // Clock
    input  logic clk,
    // Bus
    input  logic sda_wire,
    output logic scl_drv,
    output logic sda_pull
);
    timeunit 1ns;
    timeprecision 1ns;
    // Bus parked high outside frames
    initial begin
        scl_drv  = 1'b1;
        sda_pull = 1'b0;
    end
    // Wait n system clocks
    task automatic tk(input int n);
        repeat (n) @(posedge clk);
    endtask
    // One bit, data set in the low phase, sampled late in the high
    task automatic bit_io(input logic b, output logic s);
        scl_drv <= 1'b0;
        tk(2);
        sda_pull <= ~b;
        tk(2);
        scl_drv <= 1'b1;
        tk(3);
        s = sda_wire;
        tk(1);
    endtask
    // Byte MSB first, then the acknowledge slot; 1 releases SDA
    task automatic byte_io(input logic [7:0] tx, input logic a,
                           output logic [7:0] rx, output logic ak);
        for (int i = 7; i >= 0; i--)
            bit_io(tx[i], rx[i]);
        bit_io(a, ak);
    endtask
    // Start or repeated start: SDA falls with SCL high
    task automatic start_c();
        scl_drv <= 1'b0;
        tk(2);
        sda_pull <= 1'b0;
        tk(2);
        scl_drv <= 1'b1;
        tk(4);
        sda_pull <= 1'b1;
        tk(4);
    endtask
    // Stop: SDA rises with SCL high, only while we own SDA
    task automatic stop_c();
        scl_drv <= 1'b0;
        tk(2);
        sda_pull <= 1'b1;
        tk(2);
        scl_drv <= 1'b1;
        tk(4);
        sda_pull <= 1'b0;
        tk(4);
    endtask
endmodule // tws_master_model

// >>> testbench/tb_tws_slave.sv
/* Self-checking bench for the two-wire memory slave.
   Assumes the master model and the pin checker beside it. */
`include "tws_map.vh"
module tb_tws_slave;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {
        logic [2:0] pg;  // Page
        logic [7:0] wa;  // Word address
        logic [7:0] dat; // Byte written
        logic       wp;  // Protect pin
        logic       nak; // Expected data acknowledge bit
        logic [7:0] exp; // Expected read back
    } tws_row;
    tws_row rows [5] = '{'{3'h0, 8'h12, 8'h5C, 1'b0, 1'b0, 8'h5C},
                         '{3'h3, 8'hFF, 8'hA5, 1'b1, 1'b0, 8'hA5},
                         '{3'h7, 8'h00, 8'h3C, 1'b0, 1'b0, 8'h3C},
                         '{3'h4, 8'h80, 8'h01, 1'b0, 1'b0, 8'h01},
                         '{3'h4, 8'h80, 8'h77, 1'b1, 1'b1, 8'h01}};
    logic       clk = 1'b0;          // System clock
    logic       sys_rst = 1'b1;      // Reset
    logic       wp_in = 1'b0;        // Protect pin
    logic       hold_writes = 1'b0;  // Queue drain pause
    logic       scl_drv, sda_pull;   // Master side
    logic       sda_out, sda_oe;     // Slave side
    wire        sda_wire = ~(sda_oe | sda_pull); // Pulled-up wire
    logic [7:0] rd;                  // Last byte read
    logic       ak;                  // Last acknowledge bit
    int         error_cnt = 0, tests_run = 0, cyc = 0;
    always #25 clk = ~clk;
    tws_slave tws_slave_inst (.clk(clk), .sys_rst(sys_rst), .scl_in(scl_drv),
        .sda_in(sda_wire), .sda_out(sda_out), .sda_oe(sda_oe), .wp_in(wp_in),
        .hold_writes(hold_writes));
    tws_master_model tws_master_model_inst (.clk(clk), .sda_wire(sda_wire),
        .scl_drv(scl_drv), .sda_pull(sda_pull));
    // Verdict and end of run
    task automatic wrap_up();
        $display("Checks %0d, mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // Compare and count
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // One byte through the master
    task automatic bx(input logic [7:0] tx, input logic a);
        tws_master_model_inst.byte_io(tx, a, rd, ak);
    endtask
    // Slave address byte
    function automatic logic [7:0] sl(input logic [2:0] pg, input logic rw);
        return {`TWS_DEV_TYPE, pg, rw};
    endfunction
    // Start, slave address for writing, word address
    task automatic seta(input logic [2:0] pg, input logic [7:0] wa);
        tws_master_model_inst.start_c();
        bx(sl(pg, 1'b0), 1'b1);
        chk({7'h0, ak}, 8'h00);
        bx(wa, 1'b1);
        chk({7'h0, ak}, 8'h00);
    endtask
    // Single byte write then stop
    task automatic wr1(input logic [2:0] pg, input logic [7:0] wa, input logic [7:0] d);
        seta(pg, wa);
        bx(d, 1'b1);
        tws_master_model_inst.stop_c();
    endtask
    // Current address read of n bytes, last one refused
    task automatic rds(input logic [2:0] pg, input int n, input logic [31:0] e);
        tws_master_model_inst.start_c();
        bx(sl(pg, 1'b1), 1'b1);
        chk({7'h0, ak}, 8'h00);
        for (int k = 0; k < n; k++) begin
            bx(8'hFF, k == n - 1);
            chk(rd, e[31 - 8 * k -: 8]);
        end
        tws_master_model_inst.stop_c();
    endtask
    // Cycle ceiling against a hung bus
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            wrap_up();
        end
    end
    // Main sequence
    initial begin
        repeat (20) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (4) @(posedge clk);
        chk({7'h0, sda_oe}, 8'h00);
        chk({7'h0, sda_out}, 8'h00);
        foreach (rows[i]) begin
            wp_in <= rows[i].wp;
            wr1(rows[i].pg, rows[i].wa, rows[i].dat);
            chk({7'h0, ak}, {7'h0, rows[i].nak});
            seta(rows[i].pg, rows[i].wa);
            rds(rows[i].pg, 1, {rows[i].exp, 24'h0});
        end
        // Refused write keeps the counter in place
        wp_in <= 1'b1;
        wr1(3'h4, 8'h80, 8'h77);
        chk({7'h0, ak}, 8'h01);
        rds(3'h4, 1, 32'h0100_0000);
        // Queue held full across the top of memory, then drained
        wp_in <= 1'b0;
        hold_writes <= 1'b1;
        seta(3'h7, 8'hFE);
        for (int k = 0; k < 4; k++) begin
            bx(8'h11 << k[2:0] | 8'h00, 1'b1);
            chk({7'h0, ak}, 8'h00);
        end
        tws_master_model_inst.stop_c();
        hold_writes <= 1'b0;
        seta(3'h7, 8'hFE);
        rds(3'h7, 4, 32'h1122_4488);
        // Foreign type nibble is ignored
        tws_master_model_inst.start_c();
        bx(8'h30, 1'b1);
        chk({7'h0, ak}, 8'h01);
        tws_master_model_inst.stop_c();
        // Data byte cut by stop after four bits leaves memory alone
        seta(3'h0, 8'h12);
        repeat (4) tws_master_model_inst.bit_io(1'b0, ak);
        tws_master_model_inst.stop_c();
        seta(3'h0, 8'h12);
        rds(3'h0, 1, 32'h5C00_0000);
        // Reset in mid-write: line released, latch back to the page base
        seta(3'h0, 8'h40);
        sys_rst <= 1'b1;
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (4) @(posedge clk);
        chk({7'h0, sda_oe}, 8'h00);
        rds(3'h7, 1, 32'h3C00_0000);
        wrap_up();
    end
endmodule // tb_tws_slave
bind tws_slave tws_slave_monitor tws_slave_monitor_inst (.clk(clk), .sys_rst(sys_rst),
    .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
    .wp_in(wp_in), .hold_writes(hold_writes));
